// [include/rpsc_pkg.sv]
// Constants and state type of the receive packet status and counter block
package rpsc_pkg;
    // Register indices; byte address on the bus is four times the index
    localparam logic [9:0] RPSC_IDX_NZ_STATUS = 10'h104;
    localparam logic [9:0] RPSC_IDX_LATCHED = 10'h105;
    localparam logic [9:0] RPSC_IDX_IRQ_EN = 10'h106;
    localparam logic [9:0] RPSC_IDX_GOOD_B0 = 10'h108;
    localparam logic [9:0] RPSC_IDX_GOOD_B1 = 10'h109;
    localparam logic [9:0] RPSC_IDX_GOOD_B2 = 10'h10A;
    localparam logic [9:0] RPSC_IDX_CRC_B0 = 10'h10C;
    localparam logic [9:0] RPSC_IDX_CRC_B1 = 10'h10D;
    localparam logic [9:0] RPSC_IDX_CRC_B2 = 10'h10E;
    localparam logic [9:0] RPSC_IDX_ABORT_B0 = 10'h110;
    localparam logic [9:0] RPSC_IDX_ABORT_B1 = 10'h111;
    localparam logic [9:0] RPSC_IDX_ABORT_B2 = 10'h112;
    localparam logic [9:0] RPSC_IDX_SNAP_TRIG = 10'h120;
    localparam logic [9:0] RPSC_IDX_SNAP_DONE = 10'h121;
    localparam int RPSC_ADDR_W = 12;
    localparam int RPSC_DATA_W = 32;

    // Latched status and interrupt enable bit positions
    localparam int RPSC_BIT_CRC_ERROR_SEEN = 7;
    localparam int RPSC_BIT_ABORT_SEEN = 6;
    localparam int RPSC_BIT_PARTIAL_BYTE_SEEN = 5;
    localparam int RPSC_BIT_RUNT_SEEN = 4;
    localparam int RPSC_BIT_OVERSIZE_SEEN = 3;
    localparam int RPSC_BIT_CRC_COUNT_ROSE = 2;
    localparam int RPSC_BIT_ABORT_COUNT_ROSE = 1;
    localparam int RPSC_BIT_SIZE_COUNT_ROSE = 0;

    // Live nonzero indicator positions and the update bit position
    localparam int RPSC_BIT_CRC_COUNT_NONZERO = 2;
    localparam int RPSC_BIT_ABORT_COUNT_NONZERO = 1;
    localparam int RPSC_BIT_SIZE_COUNT_NONZERO = 0;
    localparam int RPSC_BIT_SNAP = 0;

    // Counter width, limits and reset values
    localparam int RPSC_CNT_W = 24;
    localparam logic [7:0] RPSC_LATCHED_RST = 8'h00;
    localparam logic [7:0] RPSC_IRQ_EN_RST = 8'h00;
    localparam logic [RPSC_CNT_W-1:0] RPSC_CNT_RST = 24'h000000;
    localparam logic [RPSC_CNT_W-1:0] RPSC_CNT_ONE = 24'h000001;
    localparam logic [RPSC_CNT_W-1:0] RPSC_CNT_MAX = 24'hFFFFFF;

    typedef struct packed {
        logic [7:0] latched;
        logic [7:0] irq_en;
        logic [RPSC_CNT_W-1:0] good_run;
        logic [RPSC_CNT_W-1:0] crc_run;
        logic [RPSC_CNT_W-1:0] abort_run;
        logic [RPSC_CNT_W-1:0] size_run;
        logic [RPSC_CNT_W-1:0] good_tally;
        logic [RPSC_CNT_W-1:0] crc_tally;
        logic [RPSC_CNT_W-1:0] abort_tally;
        logic snap_trig;
        logic snap_done;
        logic [2:0] nonzero;
        logic waitreq;
        logic [RPSC_DATA_W-1:0] rdata;
        logic irq;
        logic aborted_bytes_sel;
        logic good_bytes_sel;
    } rpsc_state_t;
endpackage

// [hw/rpsc_top.sv]
// Receive packet status flags, interrupt enables and packet counters
// Notes on behaviour
// RQ1: Bad FCS packet sets latched bit 7
// RQ2: Aborted packet sets latched bit 6
// RQ3: Non-whole-byte packet sets latched bit 5
// RQ4: Packet below minimum size sets bit 4
// RQ5: Packet above maximum size sets bit 3
// RQ6: Nonzero indicator rising sets bits 2..0
// RQ7: Live indicators show counts are nonzero
// RQ8: Per-flag enable bit gates interrupt raising
// RQ9: Host keeps FCS-count enable off without FCS
// RQ10: 24-bit count of stored unaborted packets
// RQ11: Good count includes later discarded packets
// RQ12: Good count keeps running in clear channel
// RQ13: 24-bit count of FCS errored packets
// RQ14: 24-bit count of aborted packets
// RQ15: Errored packets' bytes go to aborted tally
// RQ16: Counters read as three ascending byte registers
// RQ17: Update bit rising snapshots and restarts counters
// RQ18: Latched flags clear when status is read
// RQ19: Interrupt while any enabled flag is set
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module rpsc_top
    import rpsc_pkg::*;
#(
    parameter int P_CNT_W = RPSC_CNT_W
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Avalon-MM slave
    input wire logic [RPSC_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [RPSC_DATA_W-1:0] i_avs_writedata,
    output logic [RPSC_DATA_W-1:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // End-of-packet report from the receive framer, same clock
    input wire logic i_pkt_done,
    input wire logic i_pkt_stored,
    input wire logic i_pkt_crc_error,
    input wire logic i_pkt_abort,
    input wire logic i_pkt_partial_byte,
    input wire logic i_pkt_runt,
    input wire logic i_pkt_oversize,
    input wire logic i_clear_channel,
    // Status towards the rest of the receiver
    output logic o_crc_count_nonzero,
    output logic o_abort_count_nonzero,
    output logic o_size_count_nonzero,
    output logic o_aborted_bytes_sel,
    output logic o_good_bytes_sel,
    output logic o_irq
);

    // Byte registers are fixed at three per counter
    if (P_CNT_W != RPSC_CNT_W) begin : g_bad_width
        $error("rpsc_top: counter width must equal three bytes");
    end

    rpsc_state_t s_q;
    rpsc_state_t s_d;

    // Counters stick at full scale rather than wrapping to a small value
    function automatic logic [RPSC_CNT_W-1:0] bump(
        input logic [RPSC_CNT_W-1:0] cnt,
        input logic inc
    );
        logic [RPSC_CNT_W-1:0] r;
        r = cnt;
        if (inc && cnt != RPSC_CNT_MAX) begin
            r = cnt + RPSC_CNT_ONE;
        end
        return r;
    endfunction

    // Restart on snapshot; an event in that same cycle leaves a one
    function automatic logic [RPSC_CNT_W-1:0] run_next(
        input logic [RPSC_CNT_W-1:0] cnt,
        input logic inc,
        input logic restart
    );
        logic [RPSC_CNT_W-1:0] r;
        r = bump(cnt, inc);
        if (restart) begin
            r = inc ? RPSC_CNT_ONE : RPSC_CNT_RST;
        end
        return r;
    endfunction

    function automatic logic [7:0] read_mux(
        input rpsc_state_t s,
        input logic [9:0] idx
    );
        logic [7:0] r;
        r = 8'h00;
        case (idx)
            RPSC_IDX_NZ_STATUS: r = {5'h00, s.nonzero};
            RPSC_IDX_LATCHED: r = s.latched;
            RPSC_IDX_IRQ_EN: r = s.irq_en;
            RPSC_IDX_GOOD_B0: r = s.good_tally[7:0]; // RQ16
            RPSC_IDX_GOOD_B1: r = s.good_tally[15:8]; // RQ16
            RPSC_IDX_GOOD_B2: r = s.good_tally[23:16]; // RQ16
            RPSC_IDX_CRC_B0: r = s.crc_tally[7:0]; // RQ16
            RPSC_IDX_CRC_B1: r = s.crc_tally[15:8]; // RQ16
            RPSC_IDX_CRC_B2: r = s.crc_tally[23:16]; // RQ16
            RPSC_IDX_ABORT_B0: r = s.abort_tally[7:0]; // RQ16
            RPSC_IDX_ABORT_B1: r = s.abort_tally[15:8]; // RQ16
            RPSC_IDX_ABORT_B2: r = s.abort_tally[23:16]; // RQ16
            RPSC_IDX_SNAP_TRIG: r = {7'h00, s.snap_trig};
            RPSC_IDX_SNAP_DONE: r = {7'h00, s.snap_done};
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    logic [9:0] idx;
    logic req;
    logic accept;
    logic wr_acc;
    logic rd_acc;
    logic ev_ok;
    logic ev_crc;
    logic ev_abort;
    logic ev_partial;
    logic ev_runt;
    logic ev_over;
    logic ev_size;
    logic ev_good;
    logic snap;
    logic [7:0] set_bits;
    logic [7:0] clr_bits;
    logic [2:0] rose;
    logic [7:0] wbyte;

    assign idx = i_avs_address[RPSC_ADDR_W-1:2];
    assign req = i_avs_read | i_avs_write;
    // The master completes at the edge that sees waitrequest low
    assign accept = req & ~s_q.waitreq;
    assign wr_acc = accept & i_avs_write;
    assign rd_acc = accept & i_avs_read;
    assign wbyte = i_avs_writedata[7:0];

    // Packet-processing checks are off in clear channel mode
    assign ev_ok = i_pkt_done & ~i_clear_channel;
    assign ev_crc = ev_ok & i_pkt_crc_error;
    assign ev_abort = ev_ok & i_pkt_abort;
    assign ev_partial = ev_ok & i_pkt_partial_byte;
    assign ev_runt = ev_ok & i_pkt_runt;
    assign ev_over = ev_ok & i_pkt_oversize;
    assign ev_size = ev_partial | ev_runt | ev_over;
    // Counted when stored; later loopback or overflow drops still count
    assign ev_good = i_pkt_done & i_pkt_stored & ~ev_abort; // RQ10 RQ11 RQ12

    always_comb begin
        s_d = s_q;
        set_bits = 8'h00;
        clr_bits = 8'h00;
        rose = 3'h0;

        // Snapshot on a written 0 to 1 of the update bit
        snap = wr_acc && idx == RPSC_IDX_SNAP_TRIG
            && wbyte[RPSC_BIT_SNAP] && !s_q.snap_trig; // RQ17
        if (wr_acc && idx == RPSC_IDX_SNAP_TRIG) begin
            s_d.snap_trig = wbyte[RPSC_BIT_SNAP];
        end
        if (wr_acc && idx == RPSC_IDX_SNAP_TRIG && !wbyte[RPSC_BIT_SNAP]) begin
            s_d.snap_done = 1'b0;
        end
        if (snap) begin
            s_d.good_tally = bump(s_q.good_run, ev_good); // RQ17
            s_d.crc_tally = bump(s_q.crc_run, ev_crc); // RQ17
            s_d.abort_tally = bump(s_q.abort_run, ev_abort); // RQ17
            s_d.snap_done = 1'b1;
        end

        s_d.good_run = run_next(s_q.good_run, ev_good, snap); // RQ10 RQ12
        s_d.crc_run = run_next(s_q.crc_run, ev_crc, snap); // RQ13
        s_d.abort_run = run_next(s_q.abort_run, ev_abort, snap); // RQ14
        s_d.size_run = run_next(s_q.size_run, ev_size, snap);

        s_d.nonzero[RPSC_BIT_CRC_COUNT_NONZERO] =
            s_d.crc_run != RPSC_CNT_RST; // RQ7
        s_d.nonzero[RPSC_BIT_ABORT_COUNT_NONZERO] =
            s_d.abort_run != RPSC_CNT_RST; // RQ7
        s_d.nonzero[RPSC_BIT_SIZE_COUNT_NONZERO] =
            s_d.size_run != RPSC_CNT_RST; // RQ7
        rose = s_d.nonzero & ~s_q.nonzero; // RQ6

        set_bits[RPSC_BIT_CRC_ERROR_SEEN] = ev_crc; // RQ1
        set_bits[RPSC_BIT_ABORT_SEEN] = ev_abort; // RQ2
        set_bits[RPSC_BIT_PARTIAL_BYTE_SEEN] = ev_partial; // RQ3
        set_bits[RPSC_BIT_RUNT_SEEN] = ev_runt; // RQ4
        set_bits[RPSC_BIT_OVERSIZE_SEEN] = ev_over; // RQ5
        set_bits[RPSC_BIT_CRC_COUNT_ROSE] =
            rose[RPSC_BIT_CRC_COUNT_NONZERO]; // RQ6
        set_bits[RPSC_BIT_ABORT_COUNT_ROSE] =
            rose[RPSC_BIT_ABORT_COUNT_NONZERO]; // RQ6
        set_bits[RPSC_BIT_SIZE_COUNT_ROSE] =
            rose[RPSC_BIT_SIZE_COUNT_NONZERO]; // RQ6

        // Only bits already returned or written with a one are cleared; a new event survives
        if (rd_acc && idx == RPSC_IDX_LATCHED) begin
            clr_bits = s_q.rdata[7:0]; // RQ18
        end
        if (wr_acc && idx == RPSC_IDX_LATCHED) begin
            clr_bits = clr_bits | wbyte;
        end
        s_d.latched = (s_q.latched & ~clr_bits) | set_bits; // RQ18

        if (wr_acc && idx == RPSC_IDX_IRQ_EN) begin
            s_d.irq_en = wbyte; // RQ8
        end
        s_d.irq = |(s_d.latched & s_d.irq_en); // RQ8 RQ19

        // Byte routing for the byte tallies kept elsewhere
        if (i_pkt_done) begin
            s_d.aborted_bytes_sel = ev_crc | ev_abort | ev_size; // RQ15
            s_d.good_bytes_sel = ~(ev_crc | ev_abort | ev_size); // RQ15
        end else begin
            s_d.aborted_bytes_sel = 1'b0;
            s_d.good_bytes_sel = 1'b0;
        end

        // One wait cycle gives a registered read value at the accept edge
        if (req && s_q.waitreq) begin
            s_d.waitreq = 1'b0;
            s_d.rdata = {24'h000000, read_mux(s_q, idx)};
        end else begin
            s_d.waitreq = 1'b1;
            if (accept) begin
                s_d.rdata = {RPSC_DATA_W{1'b0}};
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q.latched <= RPSC_LATCHED_RST;
            s_q.irq_en <= RPSC_IRQ_EN_RST;
            s_q.good_run <= RPSC_CNT_RST;
            s_q.crc_run <= RPSC_CNT_RST;
            s_q.abort_run <= RPSC_CNT_RST;
            s_q.size_run <= RPSC_CNT_RST;
            s_q.good_tally <= RPSC_CNT_RST;
            s_q.crc_tally <= RPSC_CNT_RST;
            s_q.abort_tally <= RPSC_CNT_RST;
            s_q.snap_trig <= 1'b0;
            s_q.snap_done <= 1'b0;
            s_q.nonzero <= 3'h0;
            s_q.waitreq <= 1'b1;
            s_q.rdata <= 32'h00000000;
            s_q.irq <= 1'b0;
            s_q.aborted_bytes_sel <= 1'b0;
            s_q.good_bytes_sel <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_avs_readdata = s_q.rdata;
    assign o_avs_waitrequest = s_q.waitreq;
    assign o_crc_count_nonzero = s_q.nonzero[RPSC_BIT_CRC_COUNT_NONZERO];
    assign o_abort_count_nonzero = s_q.nonzero[RPSC_BIT_ABORT_COUNT_NONZERO];
    assign o_size_count_nonzero = s_q.nonzero[RPSC_BIT_SIZE_COUNT_NONZERO];
    assign o_aborted_bytes_sel = s_q.aborted_bytes_sel;
    assign o_good_bytes_sel = s_q.good_bytes_sel;
    assign o_irq = s_q.irq;

endmodule

`default_nettype wire

// [bench/rpsc_framer_model.sv]
// Receive framer model that issues end-of-packet reports
`timescale 1ns/1ps
`default_nettype none

module rpsc_framer_model (
    input wire logic i_mclk,
    input wire logic i_go,
    input wire logic [5:0] i_kind,
    input wire logic i_cc,
    output logic o_done,
    output logic [5:0] o_qual,
    output logic o_cc
);
    // Qualifiers invert outside the report cycle so stale values mean nothing
    always_ff @(posedge i_mclk) begin
        o_done <= i_go;
        o_qual <= i_go ? i_kind : ~o_qual;
        o_cc <= i_cc;
    end
endmodule

`default_nettype wire

// [bench/rpsc_top_monitor.sv]
// Concurrent checks on the status and counter block ports
`timescale 1ns/1ps
`default_nettype none

module rpsc_monitor
    import rpsc_pkg::*;
#(
    parameter int P_CNT_W = RPSC_CNT_W
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [RPSC_DATA_W-1:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic i_pkt_done,
    input wire logic i_pkt_crc_error,
    input wire logic i_pkt_abort,
    input wire logic i_pkt_partial_byte,
    input wire logic i_pkt_runt,
    input wire logic i_pkt_oversize,
    input wire logic i_clear_channel,
    input wire logic o_crc_count_nonzero,
    input wire logic o_abort_count_nonzero,
    input wire logic o_size_count_nonzero,
    input wire logic o_aborted_bytes_sel,
    input wire logic o_good_bytes_sel
);
    logic ev, sz, bad, crc_ev;
    assign ev = i_pkt_done && !i_clear_channel;
    assign sz = i_pkt_partial_byte || i_pkt_runt || i_pkt_oversize;
    assign bad = i_pkt_crc_error || i_pkt_abort || sz;
    assign crc_ev = ev && i_pkt_crc_error;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    a_one_wait: assert property ((i_avs_read || i_avs_write) &&
        o_avs_waitrequest |=> !o_avs_waitrequest) else $error("no answer");
    a_wait_pulse: assert property (!o_avs_waitrequest |=>
        o_avs_waitrequest) else $error("wait low too long");
    a_idle_rdata: assert property (o_avs_waitrequest |->
        o_avs_readdata == '0) else $error("read data outside answer");
    a_bad_bytes: assert property (ev && bad |=> o_aborted_bytes_sel
        && !o_good_bytes_sel) else $error("errored bytes misrouted");
    a_good_bytes: assert property (ev && !bad |=> o_good_bytes_sel
        && !o_aborted_bytes_sel) else $error("good bytes misrouted");
    a_sel_cause: assert property (o_good_bytes_sel ||
        o_aborted_bytes_sel |-> $past(i_pkt_done)) else $error("stray sel");
    a_crc_nz: assert property (crc_ev |=> o_crc_count_nonzero)
        else $error("crc indicator low");
    a_abort_nz: assert property (ev && i_pkt_abort |=>
        o_abort_count_nonzero) else $error("abort indicator low");
    a_size_nz: assert property (ev && sz |=> o_size_count_nonzero)
        else $error("size indicator low");
    a_crc_rise: assert property ($rose(o_crc_count_nonzero) |->
        $past(crc_ev)) else $error("crc indicator rose alone");
    c_crc: cover property (crc_ev);
    c_size: cover property (ev && sz);
    c_read: cover property (i_avs_read && !o_avs_waitrequest);
endmodule

bind rpsc_top rpsc_monitor #(.P_CNT_W(P_CNT_W)) u_mon (
    .i_mclk, .i_rst_n, .i_avs_read, .i_avs_write, .o_avs_readdata,
    .o_avs_waitrequest, .i_pkt_done, .i_pkt_crc_error, .i_pkt_abort,
    .i_pkt_partial_byte, .i_pkt_runt, .i_pkt_oversize, .i_clear_channel,
    .o_crc_count_nonzero, .o_abort_count_nonzero, .o_size_count_nonzero,
    .o_aborted_bytes_sel, .o_good_bytes_sel
);

`default_nettype wire

// [bench/tb.sv]
// Register level bench for the status and counter block
`timescale 1ns/1ps
`default_nettype none

module tb;
    import rpsc_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [RPSC_ADDR_W-1:0] addr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [RPSC_DATA_W-1:0] wdata = '0;
    logic go = 1'b0;
    logic [5:0] kind = '0;
    logic cc = 1'b0;
    logic done, ccl, irq, wreq;
    logic [5:0] qual;
    logic [RPSC_DATA_W-1:0] rdata;
    logic [31:0] d;
    logic [7:0] ltab [5] = '{8'h84, 8'h42, 8'h21, 8'h10, 8'h08};
    logic [7:0] ctab [9] = '{3, 1, 0, 2, 0, 0, 2, 0, 0};
    int failures = 0;
    int num_checks = 0;

    always #2 i_mclk = ~i_mclk;

    rpsc_framer_model u_framer (.i_mclk(i_mclk), .i_go(go), .i_kind(kind),
        .i_cc(cc), .o_done(done), .o_qual(qual), .o_cc(ccl));

    rpsc_top uut (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_pkt_done(done), .i_pkt_stored(qual[5]),
        .i_pkt_crc_error(qual[4]), .i_pkt_abort(qual[3]),
        .i_pkt_partial_byte(qual[2]), .i_pkt_runt(qual[1]),
        .i_pkt_oversize(qual[0]), .i_clear_channel(ccl),
        .o_crc_count_nonzero(), .o_abort_count_nonzero(),
        .o_size_count_nonzero(), .o_aborted_bytes_sel(),
        .o_good_bytes_sel(), .o_irq(irq));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Values are sampled before this edge's updates land
    task automatic bus(input logic w, input logic [9:0] idx,
                       input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge i_mclk);
        rd <= !w;
        wr <= w;
        addr <= {idx, 2'b00};
        wdata <= {24'h000000, wd};
        do begin
            @(posedge i_mclk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        if (n >= 50) failures++;
        d = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00);
        check(d, exp);
    endtask

    task automatic pkt(input logic [5:0] k, input logic c);
        @(posedge i_mclk);
        go <= 1'b1;
        kind <= k;
        cc <= c;
        @(posedge i_mclk);
        go <= 1'b0;
        repeat (4) @(posedge i_mclk);
    endtask

    task automatic finish_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #100000;
        failures++;
        finish_test();
    end

    initial begin
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        rdc(RPSC_IDX_IRQ_EN, 32'h0);
        rdc(RPSC_IDX_LATCHED, 32'h0);
        rdc(10'h107, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 5; i++) begin
            pkt(6'h10 >> i, 1'b0);
            rdc(RPSC_IDX_LATCHED, {24'h0, ltab[i]});
        end
        rdc(RPSC_IDX_LATCHED, 32'h0);
        rdc(RPSC_IDX_NZ_STATUS, 32'h7);
        $display("event test done");
        // Frames carry a check sequence, so the count enable may stay on
        bus(1'b1, RPSC_IDX_IRQ_EN, 8'h80);
        rdc(RPSC_IDX_IRQ_EN, 32'h80);
        check({31'h0, irq}, 32'h0);
        pkt(6'h10, 1'b0);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, RPSC_IDX_IRQ_EN, 8'h7F);
        repeat (2) @(posedge i_mclk);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, RPSC_IDX_IRQ_EN, 8'h80);
        repeat (2) @(posedge i_mclk);
        check({31'h0, irq}, 32'h1);
        rdc(RPSC_IDX_LATCHED, 32'h80);
        repeat (2) @(posedge i_mclk);
        check({31'h0, irq}, 32'h0);
        $display("interrupt test done");
        // Enough good packets to carry into the second count byte
        for (int i = 0; i < 258; i++)
            pkt(6'h20, 1'b0);
        pkt(6'h28, 1'b1);
        pkt(6'h28, 1'b0);
        rdc(RPSC_IDX_GOOD_B0, 32'h0);
        bus(1'b1, RPSC_IDX_SNAP_TRIG, 8'h01);
        rdc(RPSC_IDX_SNAP_DONE, 32'h1);
        for (int i = 0; i < 9; i++)
            rdc(10'h108 + 10'(4 * (i / 3) + i % 3), {24'h0, ctab[i]});
        bus(1'b1, RPSC_IDX_GOOD_B0, 8'hFF);
        rdc(RPSC_IDX_GOOD_B0, 32'h3);
        rdc(RPSC_IDX_NZ_STATUS, 32'h0);
        bus(1'b1, RPSC_IDX_SNAP_TRIG, 8'h00);
        rdc(RPSC_IDX_SNAP_DONE, 32'h0);
        bus(1'b1, RPSC_IDX_SNAP_TRIG, 8'h01);
        rdc(RPSC_IDX_GOOD_B0, 32'h0);
        $display("counter test done");
        finish_test();
    end
endmodule

`default_nettype wire
